// ==== rtl/nvsc_host.sv ====
// Purpose: host controller driving a nonvolatile SRAM, with store and recall sequences
// Assumes: one request at a time; a request is taken when req_valid_i and req_ready_o are both high
// Notes: every SRAM access is chip-select controlled; address moves only with ce_n high
`timescale 1ns/1ps
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int unsigned STORE_WAIT = STORE_CYC,
  parameter int unsigned PWRUP_WAIT = POWERUP_RECALL_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire nvsc_req_t req_i,
  input wire logic supply_good_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic busy_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i
);
  nvsc_state_t state_reg, state_next;
  nvsc_bus_t bus_reg, bus_next;
  nvsc_op_t op_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [2:0] step_reg;
  logic ready_reg, rsp_reg, busy_reg, dqoe_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic sg_meta_reg, sg_sync_reg;
  logic [DATA_W-1:0] dq_meta_reg, dq_sync_reg;
  logic [ADDR_W-1:0] cur_addr;
  logic is_seq, seq_last, cnt_zero, take;
  logic [CNT_W-1:0] wait_cnt;

  // address of the given step of a trigger sequence
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvsc_op_t op);
    logic [SEQ_W-1:0] a;
    a = SEQ_ADDR0;
    case (s)
      3'h0: a = SEQ_ADDR0;
      3'h1: a = SEQ_ADDR1;
      3'h2: a = SEQ_ADDR2;
      3'h3: a = SEQ_ADDR3;
      3'h4: a = SEQ_ADDR4;
      default: a = (op == NVSC_OP_STORE) ? SEQ_STORE : SEQ_RECALL;
    endcase
    return {1'b0, a};
  endfunction : seq_addr

  assign is_seq = (op_reg == NVSC_OP_STORE) || (op_reg == NVSC_OP_RECALL);
  assign seq_last = (step_reg == 3'h5);
  assign cnt_zero = (cnt_reg == '0);
  assign take = req_valid_i && ready_reg;
  assign cur_addr = is_seq ? seq_addr(step_reg, op_reg) : bus_reg.addr;
  assign wait_cnt = (op_reg == NVSC_OP_STORE) ? CNT_W'(STORE_WAIT)
                                              : CNT_W'(SOFT_RECALL_CYC);

  always_comb begin
    state_next = state_reg;
    bus_next = bus_reg;
    case (state_reg)
      NVSC_PWRUP: if (sg_sync_reg && cnt_zero) state_next = NVSC_IDLE;
      NVSC_IDLE: if (take) state_next = NVSC_SETUP;
      NVSC_SETUP: begin
        // address set while deselected
        bus_next.addr = cur_addr;
        bus_next.we_n = (op_reg != NVSC_OP_WRITE);
        bus_next.oe_n = (op_reg != NVSC_OP_READ);
        if (cnt_zero) state_next = NVSC_STROBE;
      end
      NVSC_STROBE: begin
        bus_next.ce_n = 1'b0;
        state_next = NVSC_HOLD;
      end
      NVSC_HOLD: if (cnt_zero) begin
        // one falling edge per access, released before the next
        bus_next.ce_n = 1'b1;
        bus_next.we_n = 1'b1;
        bus_next.oe_n = 1'b1;
        if (is_seq && !seq_last) state_next = NVSC_SETUP;
        else if (is_seq) state_next = NVSC_WAIT;
        else state_next = NVSC_IDLE;
      end
      NVSC_WAIT: if (cnt_zero) state_next = NVSC_IDLE;
      default: state_next = NVSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    sg_meta_reg <= supply_good_i;
    sg_sync_reg <= sg_meta_reg;
    dq_meta_reg <= dq_i;
    dq_sync_reg <= dq_meta_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_reg <= NVSC_PWRUP;
      bus_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      op_reg <= NVSC_OP_READ;
      wdata_reg <= '0;
      cnt_reg <= CNT_W'(PWRUP_WAIT);
      step_reg <= '0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      busy_reg <= 1'b1;
      dqoe_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      bus_reg <= bus_next;
      rsp_reg <= 1'b0;
      case (state_reg)
        NVSC_PWRUP: begin
          // count only once the supply reads good
          if (!sg_sync_reg) cnt_reg <= CNT_W'(PWRUP_WAIT);
          else if (!cnt_zero) cnt_reg <= cnt_reg - 1'b1;
          if (sg_sync_reg && cnt_zero) begin
            ready_reg <= 1'b1;
            busy_reg <= 1'b0;
          end
        end
        NVSC_IDLE: begin
          // write data held past the select rising edge
          dqoe_reg <= 1'b0;
          if (take) begin
            op_reg <= req_i.op;
            wdata_reg <= req_i.wdata;
            bus_reg.addr <= req_i.addr;
            step_reg <= '0;
            cnt_reg <= PHASE_CNT;
            ready_reg <= 1'b0;
            busy_reg <= 1'b1;
          end
        end
        NVSC_SETUP: begin
          cnt_reg <= cnt_zero ? PHASE_CNT : cnt_reg - 1'b1;
          dqoe_reg <= (op_reg == NVSC_OP_WRITE);
        end
        NVSC_STROBE: cnt_reg <= HOLD_CNT;
        NVSC_HOLD: begin
          if (!cnt_zero) cnt_reg <= cnt_reg - 1'b1;
          else begin
            if (is_seq && !seq_last) begin
              step_reg <= step_reg + 3'h1;
              cnt_reg <= PHASE_CNT;
            end else if (is_seq) begin
              cnt_reg <= wait_cnt;
            end else begin
              if (op_reg == NVSC_OP_READ) rdata_reg <= dq_sync_reg;
              rsp_reg <= (op_reg == NVSC_OP_READ);
              ready_reg <= 1'b1;
              busy_reg <= 1'b0;
            end
          end
        end
        NVSC_WAIT: begin
          if (!cnt_zero) cnt_reg <= cnt_reg - 1'b1;
          else begin
            ready_reg <= 1'b1;
            busy_reg <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_reg;
  assign rsp_data_o = rdata_reg;
  assign busy_o = busy_reg;
  assign ce_n_o = bus_reg.ce_n;
  assign we_n_o = bus_reg.we_n;
  assign oe_n_o = bus_reg.oe_n;
  assign addr_o = bus_reg.addr;
  assign dq_o = wdata_reg;
  assign dq_oe_o = dqoe_reg;

  // assertions
  sequence ce_fall_s;
    $fell(ce_n_o);
  endsequence

  addr_stable_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !ce_n_o |-> $stable(addr_o)) else $error("address moved while selected");
  we_high_seq_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (is_seq && !ce_n_o) |-> we_n_o) else $error("write strobe low in sequence");
  we_write_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (!ce_n_o && op_reg == NVSC_OP_WRITE && state_reg != NVSC_PWRUP) |-> !we_n_o)
    else $error("write strobe high in write");
  seq_addr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_fall_s ##0 (is_seq && step_reg == 3'h0)) |-> addr_o[SEQ_W-1:0] == SEQ_ADDR0)
    else $error("sequence does not start at first trigger");
  seq_term_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (ce_fall_s ##0 (op_reg == NVSC_OP_RECALL && seq_last))
      |-> addr_o[SEQ_W-1:0] == SEQ_RECALL) else $error("bad recall terminator");
  ce_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_fall_s |-> !ce_n_o [*2]) else $error("chip select pulse too short");
  no_access_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_reg == NVSC_WAIT) |-> (ce_n_o && busy_o && !req_ready_o))
    else $error("access during transfer");
  store_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (state_reg == NVSC_HOLD && cnt_zero && seq_last && op_reg == NVSC_OP_STORE)
      |=> cnt_reg == CNT_W'(STORE_WAIT)) else $error("store wait not loaded");
  dq_off_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (dq_oe_o && !ce_n_o) |-> !we_n_o) else $error("data driven outside write");
endmodule : nvsc_host

// ==== include/nvsc_pkg.sv ====
// Purpose: constants and types for the nonvolatile SRAM store/recall host controller
// Assumes: 10 MHz sys_clk_i, asynchronous SRAM bus with active-low strobes
// Notes: timing counts derive from printed times and the clock period
package nvsc_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEQ_W = 14;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // trigger addresses, compared on the low 14 bits
  localparam logic [SEQ_W-1:0] SEQ_ADDR0 = 14'h0E38;
  localparam logic [SEQ_W-1:0] SEQ_ADDR1 = 14'h31C7;
  localparam logic [SEQ_W-1:0] SEQ_ADDR2 = 14'h03E0;
  localparam logic [SEQ_W-1:0] SEQ_ADDR3 = 14'h3C1F;
  localparam logic [SEQ_W-1:0] SEQ_ADDR4 = 14'h303F;
  localparam logic [SEQ_W-1:0] SEQ_STORE = 14'h0FC0;
  localparam logic [SEQ_W-1:0] SEQ_RECALL = 14'h0C63;
  // times in their own units
  localparam int unsigned STORE_DURATION_MS = 10;
  localparam int unsigned SOFT_RECALL_DURATION_US = 20;
  localparam int unsigned POWERUP_RECALL_DURATION_US = 550;
  localparam int unsigned CYCLE_TIME_NS = 45;
  // least times round up to whole cycles
  localparam int unsigned STORE_CYC = (STORE_DURATION_MS * 1000000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RECALL_CYC = (SOFT_RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_RECALL_CYC =
    (POWERUP_RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PHASE_CYC = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 17;
  localparam logic [CNT_W-1:0] PHASE_CNT = CNT_W'(PHASE_CYC);
  // select held one cycle longer so read data clears the synchroniser
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(PHASE_CYC + 1);

  typedef enum logic [1:0] {
    NVSC_OP_READ = 2'h0,
    NVSC_OP_WRITE = 2'h1,
    NVSC_OP_STORE = 2'h2,
    NVSC_OP_RECALL = 2'h3
  } nvsc_op_t;

  typedef struct packed {
    nvsc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsc_req_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
  } nvsc_bus_t;

  typedef enum logic [2:0] {
    NVSC_IDLE = 3'h0,
    NVSC_SETUP = 3'h1,
    NVSC_STROBE = 3'h2,
    NVSC_HOLD = 3'h3,
    NVSC_WAIT = 3'h4,
    NVSC_PWRUP = 3'h5
  } nvsc_state_t;
endpackage : nvsc_pkg

// ==== verif/nvsc_sram_model.sv ====
// Purpose: behavioural nonvolatile SRAM on the host's far side
// Assumes: strobes from nvsc_host, sequence clocked by select falling
// Notes: undriven dq shows inverted last data; counts busy-time accesses
`timescale 1ns/1ps
module nvsc_sram_model
  import nvsc_pkg::*;
#(
  parameter int STORE_NS = 1500,
  parameter int RECALL_NS = 15000,
  parameter int PWRUP_NS = 800
) (
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic supply_good_i,
  output logic [DATA_W-1:0] dq_o,
  output int n_store_o,
  output int n_recall_o,
  output int n_viol_o
);
  localparam logic [5*SEQ_W-1:0] TAB = {SEQ_ADDR4, SEQ_ADDR3, SEQ_ADDR2, SEQ_ADDR1, SEQ_ADDR0};
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] nv [0:32767];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic busy = 1'b1;
  logic wr_cyc = 1'b0;
  logic [SEQ_W-1:0] sa;
  int step = 0;
  wire rd_on = !ce_n_i && !oe_n_i && !wr_cyc && !busy;
  assign dq_o = rd_on ? mem[addr_i] : ~last_q;
  always @(*) if (rd_on) last_q = mem[addr_i];
  task automatic xfer(input bit st, input int ns);
    busy = 1'b1;
    for (int i = 0; i < 32768; i++) begin
      if (st) nv[i] = mem[i];
      else mem[i] = nv[i]; // copy back, nv untouched
    end
    #(ns) busy = 1'b0; // timer ignores deselect
  endtask : xfer
  initial begin
    n_store_o = 0;
    n_recall_o = 0;
    n_viol_o = 0;
    for (int i = 0; i < 32768; i++) nv[i] = 8'h00;
  end
  always @(posedge supply_good_i) xfer(1'b0, PWRUP_NS);
  always @(posedge ce_n_i) if (wr_cyc && !busy) mem[addr_i] = dq_i;
  always @(negedge ce_n_i) begin
    sa = addr_i[SEQ_W-1:0];
    wr_cyc = !we_n_i;
    if (busy) n_viol_o++;
    else if (!we_n_i) step = 0;
    else if (step == 5 && (sa == SEQ_STORE || sa == SEQ_RECALL)) begin
      step = 0;
      if (sa == SEQ_STORE) n_store_o++;
      else n_recall_o++;
      fork
        xfer(sa == SEQ_STORE, (sa == SEQ_STORE) ? STORE_NS : RECALL_NS);
      join_none
    end else if (step < 5 && sa == TAB[step*SEQ_W +: SEQ_W]) step++;
    else step = (sa == SEQ_ADDR0) ? 1 : 0;
  end
endmodule : nvsc_sram_model

// ==== verif/nvsc_host_test.sv ====
// Purpose: self-checking bench for nvsc_host against the SRAM model
// Assumes: short store and power-up waits by parameter
// Notes: watches every select falling edge on the bus
`timescale 1ns/1ps
module nvsc_host_test;
  import nvsc_pkg::*;
  localparam int CYC_MAX = 5000;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic supply_good_i = 1'b0;
  nvsc_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, busy_o, ce_n_o, we_n_o, oe_n_o, dq_oe_o;
  logic [ADDR_W-1:0] addr_o;
  logic [DATA_W-1:0] rsp_data_o, dq_o, mdl_dq, dq_bus, q;
  int n_store, n_recall, n_viol;
  logic oe_seen;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] seen_q[$];
  assign dq_bus = dq_oe_o ? dq_o : mdl_dq;
  nvsc_host #(.STORE_WAIT(20), .PWRUP_WAIT(10)) DUT (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .supply_good_i(supply_good_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .busy_o(busy_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
    .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(mdl_dq)
  );
  nvsc_sram_model mdl (
    .ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o), .dq_i(dq_bus),
    .supply_good_i(supply_good_i), .dq_o(mdl_dq), .n_store_o(n_store),
    .n_recall_o(n_recall), .n_viol_o(n_viol)
  );
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge ce_n_o) begin
    seen_q.push_back({we_n_o, addr_o});
    oe_seen = oe_n_o;
  end
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xact(input nvsc_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_i = '{op, a, d};
    while (req_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    if (op == NVSC_OP_READ) while (rsp_valid_o !== 1'b1) @(negedge sys_clk_i);
    else while (req_ready_o !== 1'b1) @(negedge sys_clk_i);
    q = rsp_data_o;
  endtask : xact
  task automatic chk_seq(input logic [SEQ_W-1:0] last);
    logic [6*SEQ_W-1:0] tab;
    tab = {last, SEQ_ADDR4, SEQ_ADDR3, SEQ_ADDR2, SEQ_ADDR1, SEQ_ADDR0};
    check("seq_count", 16'(seen_q.size()), 16'h0006);
    for (int i = 0; i < 6; i++) begin
      check("seq_addr", seen_q[i], {2'b10, tab[i*SEQ_W +: SEQ_W]});
    end
    seen_q.delete();
  endtask : chk_seq
  task automatic t_powerup();
    int n;
    n = 0;
    repeat (12) @(negedge sys_clk_i);
    check("reset_busy", {busy_o, req_ready_o}, 16'h0002);
    nrst_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    check("no_supply_ready", req_ready_o, 16'h0000);
    check("no_supply_busy", 16'(busy_o), 16'h0001);
    supply_good_i = 1'b1;
    while (req_ready_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
    end
    check("pwrup_wait", 16'(n >= 10), 16'h0001);
    $display("test powerup done");
  endtask : t_powerup
  task automatic t_rw();
    logic [ADDR_W-1:0] a [4] = '{15'h0000, 15'h7FFF, 15'h4E38, 15'h1234};
    for (int i = 0; i < 4; i++) begin
      xact(NVSC_OP_WRITE, a[i], a[i][7:0] ^ 8'h5A);
      check("write_strobe", seen_q[$], {1'b0, a[i]});
      check("write_oe", 16'(oe_seen), 16'h0001);
    end
    for (int i = 0; i < 4; i++) begin
      xact(NVSC_OP_READ, a[i], 8'h00);
      check("read_strobe", seen_q[$], {1'b1, a[i]});
      check("read_oe", 16'(oe_seen), 16'h0000);
      check("read_data", q, 16'(a[i][7:0] ^ 8'h5A));
    end
    check("no_nv_cycle", 16'(n_store + n_recall), 16'h0000);
    $display("test read write done");
  endtask : t_rw
  task automatic t_nv();
    xact(NVSC_OP_WRITE, 15'h0100, 8'hA5);
    seen_q.delete();
    xact(NVSC_OP_STORE, 15'h0000, 8'h00);
    chk_seq(SEQ_STORE);
    check("store_count", 16'(n_store), 16'h0001);
    xact(NVSC_OP_WRITE, 15'h0100, 8'h3C);
    xact(NVSC_OP_READ, 15'h0100, 8'h00);
    check("after_store", q, 16'h003C);
    seen_q.delete();
    xact(NVSC_OP_RECALL, 15'h0000, 8'h00);
    chk_seq(SEQ_RECALL);
    check("recall_count", 16'(n_recall), 16'h0001);
    xact(NVSC_OP_READ, 15'h0100, 8'h00);
    check("recalled_data", q, 16'h00A5);
    check("busy_access", 16'(n_viol), 16'h0000);
    check("idle_busy", 16'(busy_o), 16'h0000);
    $display("test store recall done");
  endtask : t_nv
  initial begin
    t_powerup();
    t_rw();
    t_nv();
    close_out();
  end
endmodule : nvsc_host_test
